// file: thch_defs.svh
`ifndef THCH_DEFS_SVH
`define THCH_DEFS_SVH
`define THCH_ADDR_ARG1     8'h0E
`define THCH_ADDR_ARG0     8'h0F
`define THCH_ADDR_CMD      8'h10
`define THCH_ADDR_LAST     8'h11
`define THCH_ADDR_MINOR    8'h12
`define THCH_ADDR_CONTENTS 8'h1E
`define THCH_ADDR_TID      8'h1F
`define THCH_PAGE_FIRST    8'h20
`define THCH_PAGE_LAST     8'h9F
`define THCH_PAGE_BYTES    8'h80
`define THCH_CMD_MEASURE   8'h04
`define THCH_CMD_CONTINUE  8'h32
`define THCH_CMD_SERIAL    8'h47
`define THCH_CMD_ADDR      8'h49
`define THCH_CMD_HIST_LO   8'h80
`define THCH_CMD_HIST_HI   8'h93
`define THCH_CMD_STOP      8'hFF
`define THCH_CODE_SERIAL   8'h47
`define THCH_MINOR_REV     8'h00
`define THCH_ADDR_RESET    7'h41
`define THCH_ZERO8         8'h00
`define THCH_FIFO_DEPTH    16
`define THCH_FIFO_WIDTH    8
`endif

// file: thch_pkg.sv
package thch_pkg;
	typedef logic [7:0] thch_byte_type;
	typedef enum logic [1:0] {
		FS_IDLE = 2'b00,
		FS_REQ  = 2'b01,
		FS_FILL = 2'b10
	} thch_fill_state_type;
endpackage

// file: thch_fifo.sv
`timescale 1ns/1ps
module thch_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             ready_reg;
	logic             push;
	logic             pop;

	// ready comes from a flop so the producer never sees a combinational path
	assign in_ready  = ready_reg;
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			ready_reg  <= 1'b1;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			ready_reg <= (count_next != (AW+1)'(DEPTH));
		end
	end
endmodule

// file: thch_handler.sv
`timescale 1ns/1ps
`include "thch_defs.svh"
module thch_handler (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  reg_wr_en,
	input  wire logic                  reg_rd_en,
	input  wire logic [7:0]            reg_addr,
	input  wire thch_pkg::thch_byte_type reg_wdata,
	output thch_pkg::thch_byte_type    reg_rdata,
	input  wire logic                  read_done,
	input  wire logic [1:0]            gpio_pin,
	input  wire logic [31:0]           serial_number,
	input  wire logic                  hist_readout_en,
	input  wire logic                  hist_avail,
	input  wire logic                  state_busy,
	input  wire thch_pkg::thch_byte_type hist_data,
	input  wire logic                  hist_valid,
	output logic                       hist_ready,
	output logic                       hist_req,
	output logic [4:0]                 hist_sel,
	output logic                       seq_halt,
	output logic                       seq_resume,
	output logic                       meas_start,
	output logic                       meas_run,
	output logic                       seq_idle,
	output logic [6:0]                 bus_address
);
	import thch_pkg::*;

	thch_byte_type       page_mem [128];
	thch_byte_type       cmd_reg;
	thch_byte_type       arg0_reg;
	thch_byte_type       arg1_reg;
	thch_byte_type       last_cmd_reg;
	thch_byte_type       contents_reg;
	thch_byte_type       tid_reg;
	thch_byte_type       page_code_reg;
	thch_byte_type       rdata_reg;
	thch_byte_type       rdata_next;
	thch_fill_state_type fill_reg;
	logic [6:0]          fill_idx_reg;
	logic [6:0]          addr_reg;
	logic                cmd_pend_reg;
	logic                stop_pend_reg;
	logic                halt_reg;
	logic                resume_reg;
	logic                start_reg;
	logic                run_reg;
	logic                idle_reg;
	logic                req_reg;
	logic [1:0]          sync1_reg;
	logic [1:0]          sync2_reg;
	logic [1:0]          sync3_reg;
	logic [1:0]          pin_reg;
	logic                pin_cond;
	logic                in_page;
	logic                adv_ok;
	logic                start_fill;
	logic                fill_done;
	logic                fifo_valid;
	thch_byte_type       fifo_data;
	logic                fifo_pop;

	assign reg_rdata   = rdata_reg;
	assign hist_req    = req_reg;
	assign hist_sel    = page_code_reg[4:0];
	assign seq_halt    = halt_reg;
	assign seq_resume  = resume_reg;
	assign meas_start  = start_reg;
	assign meas_run    = run_reg;
	assign seq_idle    = idle_reg;
	assign bus_address = addr_reg;

	////////////////////////////////////////////////////////////////////////
	// pin levels: a change is taken once the second and third stages agree
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
			sync3_reg <= 2'h0;
			pin_reg   <= 2'h0;
		end else begin
			sync1_reg <= gpio_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			if (sync2_reg == sync3_reg)
				pin_reg <= sync3_reg;
		end
	end

	// bits 7:4 of argument 0 are ignored; the sum form keeps pins separate
	assign pin_cond = ({1'b0, arg0_reg[1] & pin_reg[1], 1'b0} +
	                   {2'b00, arg0_reg[0] & pin_reg[0]}) ==
	                  ({1'b0, arg0_reg[3], 1'b0} + {2'b00, arg0_reg[2]});

	////////////////////////////////////////////////////////////////////////
	// register port
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg      <= `THCH_ZERO8;
			arg0_reg     <= `THCH_ZERO8;
			arg1_reg     <= `THCH_ZERO8;
			cmd_pend_reg <= 1'b0;
		end else begin
			// decode waits one cycle so the byte write is complete
			cmd_pend_reg <= reg_wr_en && reg_addr == `THCH_ADDR_CMD;
			if (reg_wr_en) begin
				case (reg_addr)
				`THCH_ADDR_CMD:  cmd_reg  <= reg_wdata;
				`THCH_ADDR_ARG0: arg0_reg <= reg_wdata;
				`THCH_ADDR_ARG1: arg1_reg <= reg_wdata;
				default:         ;
				endcase
			end
		end
	end

	always_comb begin
		rdata_next = `THCH_ZERO8;
		if (reg_addr >= `THCH_PAGE_FIRST && reg_addr <= `THCH_PAGE_LAST)
			rdata_next = page_mem[reg_addr[6:0]];
		else begin
			case (reg_addr)
			`THCH_ADDR_ARG1:     rdata_next = arg1_reg;
			`THCH_ADDR_ARG0:     rdata_next = arg0_reg;
			`THCH_ADDR_CMD:      rdata_next = cmd_reg;
			`THCH_ADDR_LAST:     rdata_next = last_cmd_reg;
			`THCH_ADDR_MINOR:    rdata_next = `THCH_MINOR_REV;
			`THCH_ADDR_CONTENTS: rdata_next = contents_reg;
			`THCH_ADDR_TID:      rdata_next = tid_reg;
			default:             rdata_next = `THCH_ZERO8;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rdata_reg <= `THCH_ZERO8;
		else if (reg_rd_en)
			rdata_reg <= rdata_next;
	end

	////////////////////////////////////////////////////////////////////////
	// command execution
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_cmd_reg <= `THCH_ZERO8;
			addr_reg     <= `THCH_ADDR_RESET;
			start_reg    <= 1'b0;
			resume_reg   <= 1'b0;
		end else begin
			start_reg  <= 1'b0;
			resume_reg <= 1'b0;
			if (cmd_pend_reg) begin
				last_cmd_reg <= cmd_reg;
				case (cmd_reg)
				`THCH_CMD_MEASURE:  start_reg  <= 1'b1;
				`THCH_CMD_CONTINUE: resume_reg <= halt_reg;
				`THCH_CMD_ADDR:
					if (pin_cond)
						addr_reg <= arg1_reg[7:1];
				default: ;
				endcase
			end
		end
	end

	// a stop never cuts the running state short; it waits for busy to drop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_pend_reg <= 1'b0;
			run_reg       <= 1'b0;
			idle_reg      <= 1'b0;
		end else begin
			idle_reg <= 1'b0;
			if (stop_pend_reg && !state_busy) begin
				stop_pend_reg <= 1'b0;
				run_reg       <= 1'b0;
				idle_reg      <= 1'b1;
			end else if (cmd_pend_reg && cmd_reg == `THCH_CMD_STOP)
				stop_pend_reg <= 1'b1;
			else if (cmd_pend_reg && cmd_reg == `THCH_CMD_MEASURE)
				run_reg <= 1'b1;
		end
	end

	// a new histogram wins over a continue issued in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			halt_reg <= 1'b0;
		else if (hist_avail && hist_readout_en)
			halt_reg <= 1'b1;
		else if ((cmd_pend_reg && cmd_reg == `THCH_CMD_CONTINUE) || idle_reg)
			halt_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// histogram page filling
	assign in_page = contents_reg >= `THCH_CMD_HIST_LO &&
	                 contents_reg <= `THCH_CMD_HIST_HI;
	// the last quarter of the last channel has no successor
	assign adv_ok = read_done && in_page && contents_reg != `THCH_CMD_HIST_HI;
	assign start_fill = fill_reg == FS_IDLE && (adv_ok || (cmd_pend_reg &&
	                    cmd_reg >= `THCH_CMD_HIST_LO &&
	                    cmd_reg <= `THCH_CMD_HIST_HI));
	assign fifo_pop  = fill_reg == FS_FILL && fifo_valid;
	assign fill_done = fifo_pop && fill_idx_reg == 7'h7F;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fill_reg      <= FS_IDLE;
			fill_idx_reg  <= 7'h00;
			page_code_reg <= `THCH_CMD_HIST_LO;
			req_reg       <= 1'b0;
		end else begin
			req_reg <= 1'b0;
			case (fill_reg)
			FS_IDLE:
				if (start_fill) begin
					// code+1 carries the quarter into the channel field
					page_code_reg <= adv_ok ? contents_reg + 8'h01 :
					                 cmd_reg;
					fill_reg      <= FS_REQ;
				end
			FS_REQ: begin
				req_reg      <= 1'b1;
				fill_idx_reg <= 7'h00;
				fill_reg     <= FS_FILL;
			end
			FS_FILL:
				if (fifo_pop) begin
					fill_idx_reg <= fill_idx_reg + 7'h01;
					if (fill_done)
						fill_reg <= FS_IDLE;
				end
			default: fill_reg <= FS_IDLE;
			endcase
		end
	end

	// page byte i sits at location 0x20+i, so index is address bits 6:0
	always_ff @(posedge sys_clk) begin
		if (fifo_pop)
			page_mem[fill_idx_reg + 7'(`THCH_PAGE_FIRST)] <= fifo_data;
		else if (cmd_pend_reg && cmd_reg == `THCH_CMD_SERIAL) begin
			page_mem[7'h20] <= serial_number[7:0];
			page_mem[7'h21] <= serial_number[15:8];
			page_mem[7'h22] <= serial_number[23:16];
			page_mem[7'h23] <= serial_number[31:24];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			contents_reg <= `THCH_ZERO8;
			tid_reg      <= `THCH_ZERO8;
		end else if (fill_done) begin
			contents_reg <= page_code_reg;
			tid_reg      <= tid_reg + 8'h01;
		end else if (cmd_pend_reg && cmd_reg == `THCH_CMD_SERIAL) begin
			contents_reg <= `THCH_CODE_SERIAL;
			tid_reg      <= tid_reg + 8'h01;
		end
	end

	thch_fifo #(
		.WIDTH (`THCH_FIFO_WIDTH),
		.DEPTH (`THCH_FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_data   (hist_data),
		.in_valid  (hist_valid),
		.in_ready  (hist_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_decode_after_wr: assert property (reg_wr_en && reg_addr ==
		`THCH_ADDR_CMD |=> cmd_pend_reg) else $error("no decode");
	a_halt_on_ready: assert property (hist_avail && hist_readout_en
		|=> seq_halt) else $error("no halt");
	a_measure_start: assert property (cmd_pend_reg && cmd_reg ==
		`THCH_CMD_MEASURE |=> meas_start ##1 !meas_start)
		else $error("bad start");
	a_continue_resume: assert property (cmd_pend_reg && cmd_reg ==
		`THCH_CMD_CONTINUE && halt_reg && !hist_avail |=> seq_resume &&
		!seq_halt) else $error("no resume");
	a_addr_blocked: assert property (cmd_pend_reg && cmd_reg ==
		`THCH_CMD_ADDR && !pin_cond |=> $stable(bus_address))
		else $error("addr moved");
	a_addr_applied: assert property (cmd_pend_reg && cmd_reg ==
		`THCH_CMD_ADDR && pin_cond |=> bus_address == $past(arg1_reg[7:1]))
		else $error("addr wrong");
	a_stop_waits: assert property (stop_pend_reg && state_busy
		|=> stop_pend_reg && !seq_idle) else $error("stop early");
	a_stop_ends_run: assert property (stop_pend_reg && !state_busy
		|=> !meas_run && seq_idle) else $error("run kept");
	a_last_command: assert property (cmd_pend_reg
		|=> last_cmd_reg == $past(cmd_reg)) else $error("last");
	a_serial_page: assert property (cmd_pend_reg && cmd_reg ==
		`THCH_CMD_SERIAL && fill_reg != FS_FILL |=> contents_reg ==
		`THCH_CODE_SERIAL) else $error("serial");
	a_tag_changes: assert property (fill_done |=> tid_reg != $past(tid_reg)
		&& contents_reg == $past(page_code_reg)) else $error("tag");
	a_quarter_advance: assert property (adv_ok && fill_reg == FS_IDLE
		|=> page_code_reg == $past(contents_reg) + 8'h01 ##1 hist_req)
		else $error("advance");
	a_code_range: assert property (fill_reg != FS_IDLE |->
		page_code_reg >= `THCH_CMD_HIST_LO && page_code_reg <=
		`THCH_CMD_HIST_HI) else $error("code range");

	c_fill_page: cover property (fill_done);
	c_advance: cover property (adv_ok && fill_reg == FS_IDLE);
	c_stop_wait: cover property (stop_pend_reg && state_busy ##1
		stop_pend_reg && !state_busy ##1 seq_idle);
	c_addr_change: cover property (cmd_pend_reg && cmd_reg == `THCH_CMD_ADDR
		&& pin_cond);
endmodule

// file: thch_core_model.sv
`timescale 1ns/1ps
module thch_core_model (
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  wire logic                    hist_req,
	input  wire logic [4:0]              hist_sel,
	input  wire logic                    hist_ready,
	output thch_pkg::thch_byte_type      hist_data,
	output logic                         hist_valid
);
	import thch_pkg::*;
	logic [7:0] left_reg;
	logic [6:0] idx_reg;
	logic [4:0] sel_reg;
	////////////////////////////////////////////////////////////////////////
	// streams one quarter; random gaps make the fifo see a slow producer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			left_reg   <= 8'h00;
			idx_reg    <= 7'h00;
			sel_reg    <= 5'h00;
			hist_valid <= 1'b0;
			hist_data  <= 8'h00;
		end else if (hist_req) begin
			left_reg <= 8'h80;
			idx_reg  <= 7'h00;
			sel_reg  <= hist_sel;
		end else if (hist_valid && hist_ready) begin
			// released data must not keep looking like the last byte
			hist_valid <= 1'b0;
			hist_data  <= ~hist_data;
			left_reg   <= left_reg - 8'h01;
			idx_reg    <= idx_reg + 7'h01;
		end else if (!hist_valid && left_reg != 8'h00 && $urandom % 4 != 0) begin
			hist_valid <= 1'b1;
			hist_data  <= 8'(sel_reg * 8'h0D + {1'b0, idx_reg});
		end
	end
endmodule

// file: thch_handler_test.sv
`timescale 1ns/1ps
`include "thch_defs.svh"
module thch_handler_test;
	import thch_pkg::*;
	logic          sys_clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          reg_wr_en = 1'b0;
	logic          reg_rd_en = 1'b0;
	logic [7:0]    reg_addr = 8'h00;
	thch_byte_type reg_wdata = 8'h00;
	thch_byte_type reg_rdata;
	logic          read_done = 1'b0;
	logic [1:0]    gpio_pin = 2'b00;
	logic [31:0]   serial_number = 32'h0000_0000;
	logic          hist_readout_en = 1'b0;
	logic          hist_avail = 1'b0;
	logic          state_busy = 1'b0;
	thch_byte_type hist_data;
	logic          hist_valid, hist_ready, hist_req, seq_halt;
	logic          seq_resume, meas_start, meas_run, seq_idle;
	logic [4:0]    hist_sel;
	logic [6:0]    bus_address;
	logic [6:0]    exp_a;
	thch_byte_type v, t;
	int            miscompares = 0;
	int            compares = 0;
	int            n_start = 0;
	int            n_resume = 0;
	int            n_idle = 0;
	int            n_req = 0;

	thch_handler DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .read_done(read_done),
		.gpio_pin(gpio_pin), .serial_number(serial_number),
		.hist_readout_en(hist_readout_en), .hist_avail(hist_avail),
		.state_busy(state_busy), .hist_data(hist_data),
		.hist_valid(hist_valid), .hist_ready(hist_ready),
		.hist_req(hist_req), .hist_sel(hist_sel), .seq_halt(seq_halt),
		.seq_resume(seq_resume), .meas_start(meas_start),
		.meas_run(meas_run), .seq_idle(seq_idle),
		.bus_address(bus_address));
	thch_core_model core (.sys_clk(sys_clk), .rst_n(rst_n),
		.hist_req(hist_req), .hist_sel(hist_sel), .hist_ready(hist_ready),
		.hist_data(hist_data), .hist_valid(hist_valid));

	always #5 sys_clk = ~sys_clk;
	// pulses last one cycle, so count them rather than try to catch them
	always @(posedge sys_clk) begin
		if (meas_start === 1'b1) n_start++;
		if (seq_resume === 1'b1) n_resume++;
		if (seq_idle === 1'b1) n_idle++;
		if (hist_req === 1'b1) n_req++;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic thch_byte_type exp_byte(input logic [4:0] s,
		input logic [6:0] i);
		return 8'(s * 8'h0D + {1'b0, i});
	endfunction
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input thch_byte_type d);
		@(negedge sys_clk);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output thch_byte_type d);
		@(negedge sys_clk);
		reg_rd_en = 1'b1;
		reg_addr = a;
		@(negedge sys_clk);
		reg_rd_en = 1'b0;
		d = reg_rdata;
	endtask
	task automatic wait_code(input thch_byte_type c);
		int i;
		for (i = 0; i < 600; i++) begin
			rd(`THCH_ADDR_CONTENTS, v);
			if (v === c) break;
		end
		if (i == 600) begin
			miscompares++;
			$display("[ERR] contents expected %h seen %h", c, v);
			summarize();
		end
	endtask
	task automatic page(input logic [4:0] s);
		for (int k = 0; k < 128; k += 63) begin
			rd(8'(`THCH_PAGE_FIRST + k), v);
			chk("page byte", exp_byte(s, 7'(k)), v);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge sys_clk);
		miscompares++;
		$display("[ERR] run expected to end seen hang");
		summarize();
	end
	initial begin
		void'($urandom(32'h324f));
		serial_number = $urandom;
		cyc(10);
		rst_n = 1'b1;
		chk("bus_address", 7'h41, bus_address);
		chk("hist_ready", 1'b1, hist_ready);
		rd(`THCH_ADDR_LAST, v);
		chk("last_command", 8'h00, v);
		wr(`THCH_ADDR_LAST, 8'h5A);
		rd(`THCH_ADDR_LAST, v);
		chk("last_command ro", 8'h00, v);
		rd(`THCH_ADDR_MINOR, v);
		chk("minor", 8'h00, v);
		rd(8'hF0, v);
		chk("unmapped", 8'h00, v);
		$display("test reset done");
		wr(`THCH_ADDR_CMD, `THCH_CMD_MEASURE);
		cyc(3);
		chk("meas_start", 1, n_start);
		chk("meas_run", 1'b1, meas_run);
		rd(`THCH_ADDR_CMD, v);
		chk("host_command", 8'h04, v);
		hist_readout_en = 1'b1;
		hist_avail = 1'b1;
		cyc(1);
		hist_avail = 1'b0;
		cyc(2);
		chk("seq_halt", 1'b1, seq_halt);
		wr(`THCH_ADDR_CMD, `THCH_CMD_CONTINUE);
		cyc(3);
		chk("seq_resume", 1, n_resume);
		hist_avail = 1'b1;
		cyc(1);
		hist_avail = 1'b0;
		$display("test halt done");
		// stop must wait out a busy state
		state_busy = 1'b1;
		wr(`THCH_ADDR_CMD, `THCH_CMD_STOP);
		cyc(5);
		chk("meas_run busy", 1'b1, meas_run);
		chk("seq_idle busy", 0, n_idle);
		state_busy = 1'b0;
		cyc(3);
		chk("meas_run", 1'b0, meas_run);
		chk("seq_idle", 1, n_idle);
		chk("seq_halt", 1'b0, seq_halt);
		rd(`THCH_ADDR_LAST, v);
		chk("last_command", 8'hFF, v);
		hist_readout_en = 1'b0;
		$display("test stop done");
		exp_a = 7'h41;
		for (int k = 0; k < 12; k++) begin
			gpio_pin = 2'($urandom);
			t = (k == 0) ? 8'h00 : {4'h0, 4'($urandom)};
			v = {7'($urandom), 1'b0};
			cyc(6);
			wr(`THCH_ADDR_ARG0, t);
			wr(`THCH_ADDR_ARG1, v);
			wr(`THCH_ADDR_CMD, `THCH_CMD_ADDR);
			cyc(3);
			if ({t[1] & gpio_pin[1], t[0] & gpio_pin[0]} == t[3:2])
				exp_a = v[7:1];
			chk("bus_address", exp_a, bus_address);
		end
		$display("test address done");
		rd(`THCH_ADDR_TID, t);
		wr(`THCH_ADDR_CMD, `THCH_CMD_SERIAL);
		cyc(3);
		rd(`THCH_ADDR_CONTENTS, v);
		chk("contents", 8'h47, v);
		for (int k = 0; k < 4; k++) begin
			rd(8'(`THCH_PAGE_FIRST + k), v);
			chk("serial", serial_number[8*k +: 8], v);
		end
		rd(`THCH_ADDR_TID, v);
		chk("tid changed", 1'b1, v !== t);
		$display("test serial done");
		rd(`THCH_ADDR_TID, t);
		wr(`THCH_ADDR_CMD, 8'h83);
		wait_code(8'h83);
		chk("hist_sel", 5'h03, hist_sel);
		page(5'h03);
		rd(`THCH_ADDR_TID, v);
		chk("tid changed", 1'b1, v !== t);
		read_done = 1'b1;
		cyc(1);
		read_done = 1'b0;
		wait_code(8'h84);
		chk("hist_sel", 5'h04, hist_sel);
		page(5'h04);
		wr(`THCH_ADDR_CMD, `THCH_CMD_HIST_HI);
		wait_code(8'h93);
		read_done = 1'b1;
		cyc(1);
		read_done = 1'b0;
		cyc(10);
		rd(`THCH_ADDR_CONTENTS, v);
		chk("last quarter", 8'h93, v);
		chk("hist_sel last", 5'h13, hist_sel);
		chk("hist_req count", 3, n_req);
		$display("test histogram done");
		summarize();
	end
endmodule
